// File: core/rsc_regs.svh
// Purpose: Register map, field positions and timing counts of the reset source controller
// Assumes: AXI4-Lite register index times four gives the byte address
// Notes: Definitions only
//
// Behaviour
// - Six causes (power-on, brown-out, pin, hard fault, watchdog, software) drive one internal reset.
// - Any internal reset returns the control fields to reset values; only cause flags depend on the source.
// - While supply is low the block holds reset, then execution starts from address 0000H.
// - A power-on reset leaves the cold-start flag (power control bit 4) at 1.
// - The cold-start flag keeps its value across every reset but power-on; software clears it.
// - A brown-out with the brown-out reset enable (bit 2) at 1 resets the device.
// - A brown-out reset sets the brown-out flag (bit 1); only power-on, brown-out or software change it.
// - The pin reset is applied synchronously to the running clock.
// - Reset stays while the pin is low and ends after the pin returns high.
// - A pin low in power-down restarts the clock first, and reset follows once the clock is stable.
// - A pin reset sets the pin flag (auxiliary bit 6); only power-on, pin reset or software change it.
// - A program counter overflow resets the device and sets the hard-fault flag (auxiliary bit 5).
// - In debug mode with the debug enable config at 0 the overflow sets the hard-fault flag and interrupt status bit 1, with no reset.
// - The hard-fault flag survives all resets but power-on and hard fault; software clears it.
`ifndef RSC_REGS_SVH
`define RSC_REGS_SVH

// ****************************************
// Register indices
// ****************************************
`define RSC_IDX_PWR 8'h87
`define RSC_IDX_AUX1 8'hA2
`define RSC_IDX_BOD0 8'hA3
`define RSC_IDX_IRQ_STAT 8'hB0
`define RSC_IDX_IRQ_MASK 8'hB1

// ****************************************
// Field positions
// ****************************************
`define RSC_PWR_COLD 4
`define RSC_PWR_GF_HI 3
`define RSC_PWR_GF_LO 2
`define RSC_PWR_PD 1
`define RSC_AUX_SW 7
`define RSC_AUX_PIN 6
`define RSC_AUX_HF 5
`define RSC_AUX_GF2 3
`define RSC_BOD_EN 2
`define RSC_BOD_FLAG 1
`define RSC_BOD_STAT 0
`define RSC_EVT_BOD 0
`define RSC_EVT_HFDBG 1
`define RSC_EVT_PIN 2
`define RSC_EVT_WDT 3
`define RSC_EVT_SW 4
`define RSC_EVT_W 5

// ****************************************
// Values and timing
// ****************************************
`define RSC_BOOT_ADDR 16'h0000
`define RSC_RESP_OKAY 2'h0
`define RSC_RESP_SLVERR 2'h2
`define RSC_PIN_MIN_LOW 24
`define RSC_CLK_MHZ 50
`define RSC_HOLD_NS 1000
`define RSC_HOLD_CYC ((`RSC_HOLD_NS * `RSC_CLK_MHZ + 999) / 1000)

`endif

// File: core/rsc_pkg.sv
// Purpose: Types of the reset source controller
// Assumes: Nothing
// Notes: Gray codes along the wake path; a trip from RUN to RESET changes both bits
`default_nettype none
package rsc_pkg;

  typedef enum logic [1:0] {
    RSC_RUN = 2'h0,
    RSC_WAKE = 2'h1,
    RSC_RESET = 2'h3,
    RSC_HOLD = 2'h2
  } rsc_state_type;

endpackage : rsc_pkg
`default_nettype wire

// File: core/rsc_sync.sv
// Purpose: Two-flop synchroniser for asynchronous levels
// Assumes: Inputs are slow levels
// Notes: First stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module rsc_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage_reg <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      stage_reg <= d;
      q <= stage_reg;
    end
  end

endmodule : rsc_sync
`default_nettype wire

// File: core/rsc_pin_filter.sv
// Purpose: Minimum low time filter for the reset pin
// Assumes: Input already synchronised
// Notes: Count saturates at the minimum
`timescale 1ns/1ps
`default_nettype none
module rsc_pin_filter #(
  parameter int MIN_LOW = 24
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Pin level and verdict
  input wire logic pinLow,
  output logic pinValid
);

  localparam int CW = $clog2(MIN_LOW + 1);
  localparam logic [CW-1:0] LIMIT = CW'(MIN_LOW);

  logic [CW-1:0] count_reg;

  generate
    if (MIN_LOW < 1) begin : g_check
      $error("MIN_LOW must be at least one");
    end
  endgenerate

  // Count consecutive low clocks
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= '0;
    end else if (!pinLow) begin
      count_reg <= '0;
    end else if (count_reg != LIMIT) begin
      count_reg <= count_reg + CW'(1);
    end
  end

  assign pinValid = (count_reg == LIMIT);

  min_low_count_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(pinValid) |-> $past(pinLow, 2) && !$past(pinValid))
    else $error("Pin verdict without a low run");

endmodule : rsc_pin_filter
`default_nettype wire

// File: core/rsc_controller.sv
// Purpose: Reset source combiner with cause flags and AXI4-Lite registers
// Assumes: rst_b is the power-on reset, low while supply is below threshold
// Notes: clk is the always-on block clock; the system clock is requested out
`timescale 1ns/1ps
`default_nettype none
`include "rsc_regs.svh"
module rsc_controller #(
  parameter int ADDR_W = 12,
  parameter int PIN_MIN_LOW = `RSC_PIN_MIN_LOW,
  parameter int HOLD_CYC = `RSC_HOLD_CYC
) (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic rst_b,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Asynchronous inputs
  input wire logic resetPin_b,
  input wire logic brownoutLow,
  input wire logic clockStable,
  // Same-domain sources
  input wire logic pcOverflow,
  input wire logic watchdogExpire,
  input wire logic softwareRequest,
  input wire logic debugMode,
  input wire logic debugEnableConfig,
  input wire logic borEnableConfig,
  // Outputs
  output logic coreReset,
  output logic clockWakeRequest,
  output logic [15:0] bootAddress,
  output logic irq
);

  generate
    if (ADDR_W < 10 || HOLD_CYC < 1 || PIN_MIN_LOW < 1) begin : g_check
      $error("ADDR_W below 10 or zero count");
    end
  endgenerate

  // ****************************************
  // Decode
  // ****************************************
  function automatic logic regMapped(input logic [7:0] idx);
    regMapped = (idx == `RSC_IDX_PWR) || (idx == `RSC_IDX_AUX1) || (idx == `RSC_IDX_BOD0) ||
                (idx == `RSC_IDX_IRQ_STAT) || (idx == `RSC_IDX_IRQ_MASK);
  endfunction : regMapped

  // ****************************************
  // Input synchronisers and pin filter
  // ****************************************
  logic [2:0] syncOut;
  logic pinLowS;
  logic borLowS;
  logic clkStableS;
  logic pinValid;

  rsc_sync #(.WIDTH(3), .RESET_VAL(3'h4)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({resetPin_b, brownoutLow, clockStable}),
    .q(syncOut)
  );

  assign pinLowS = !syncOut[2];
  assign borLowS = syncOut[1];
  assign clkStableS = syncOut[0];

  rsc_pin_filter #(.MIN_LOW(PIN_MIN_LOW)) u_filter (
    .clk(clk),
    .rst_b(rst_b),
    .pinLow(pinLowS),
    .pinValid(pinValid)
  );

  // ****************************************
  // Registers and sources
  // ****************************************
  localparam int HW = $clog2(HOLD_CYC + 1);

  rsc_pkg::rsc_state_type state_reg;
  rsc_pkg::rsc_state_type state_next;
  logic [HW-1:0] holdCount_reg;
  logic coldFlag_reg;
  logic [1:0] gf_reg;
  logic powerDown_reg;
  logic swFlag_reg;
  logic pinFlag_reg;
  logic hfFlag_reg;
  logic gf2_reg;
  logic borEnable_reg;
  logic borFlag_reg;
  logic borPrev_reg;
  logic [`RSC_EVT_W-1:0] irqStat_reg;
  logic [`RSC_EVT_W-1:0] irqMask_reg;
  logic [`RSC_EVT_W-1:0] evt;
  logic borTrip;
  logic hfSuppressed;
  logic hfReset;
  logic trip;
  logic pinEvent;
  logic wrFire;
  logic rdFire;
  logic [7:0] wrIdx;
  logic [7:0] rdIdx;
  logic [7:0] wrByte;
  logic wrLane;
  logic [7:0] readMux;

  assign borTrip = borLowS && borEnable_reg;
  assign hfSuppressed = pcOverflow && debugMode && !debugEnableConfig;
  assign hfReset = pcOverflow && !hfSuppressed;
  assign trip = pinValid || borTrip || hfReset || watchdogExpire || softwareRequest;
  assign pinEvent = ((state_reg == rsc_pkg::RSC_WAKE) && clkStableS) || (pinValid && !powerDown_reg &&
                    (state_reg == rsc_pkg::RSC_RUN || state_reg == rsc_pkg::RSC_HOLD));

  // ****************************************
  // Reset sequencer
  // ****************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      rsc_pkg::RSC_RUN: begin
        if (powerDown_reg && pinLowS) begin
          state_next = rsc_pkg::RSC_WAKE;
        end else if (trip) begin
          state_next = rsc_pkg::RSC_RESET;
        end
      end
      rsc_pkg::RSC_WAKE: begin
        if (clkStableS) begin
          state_next = rsc_pkg::RSC_RESET;
        end
      end
      rsc_pkg::RSC_RESET: begin
        if (!pinLowS && !borTrip) begin
          state_next = rsc_pkg::RSC_HOLD;
        end
      end
      rsc_pkg::RSC_HOLD: begin
        if (trip) begin
          state_next = rsc_pkg::RSC_RESET;
        end else if (holdCount_reg == '0) begin
          state_next = rsc_pkg::RSC_RUN;
        end
      end
      default: begin
        state_next = rsc_pkg::RSC_RESET;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= rsc_pkg::RSC_RESET;
      coreReset <= 1'b1;
      clockWakeRequest <= 1'b0;
    end else begin
      state_reg <= state_next;
      coreReset <= (state_next == rsc_pkg::RSC_RESET) || (state_next == rsc_pkg::RSC_HOLD);
      clockWakeRequest <= (state_next == rsc_pkg::RSC_WAKE);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      holdCount_reg <= HW'(HOLD_CYC);
    end else if (state_reg != rsc_pkg::RSC_HOLD) begin
      holdCount_reg <= HW'(HOLD_CYC - 1);
    end else if (holdCount_reg != '0) begin
      holdCount_reg <= holdCount_reg - HW'(1);
    end
  end

  // Fetch start address after every reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bootAddress <= `RSC_BOOT_ADDR;
    end else if (coreReset) begin
      bootAddress <= `RSC_BOOT_ADDR;
    end
  end

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  assign awready = awvalid && wvalid && !bvalid;
  assign wready = awready;
  assign wrFire = awready;
  assign arready = !rvalid;
  assign rdFire = arvalid && arready;
  assign wrIdx = awaddr[9:2];
  assign rdIdx = araddr[9:2];
  assign wrByte = wdata[7:0];
  assign wrLane = wrFire && wstrb[0];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bvalid <= 1'b0;
      bresp <= `RSC_RESP_OKAY;
    end else if (wrFire) begin
      bvalid <= 1'b1;
      bresp <= regMapped(wrIdx) ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_comb begin
    readMux = 8'h00;
    case (rdIdx)
      `RSC_IDX_PWR: begin
        readMux[`RSC_PWR_COLD] = coldFlag_reg;
        readMux[`RSC_PWR_GF_HI:`RSC_PWR_GF_LO] = gf_reg;
        readMux[`RSC_PWR_PD] = powerDown_reg;
      end
      `RSC_IDX_AUX1: begin
        readMux[`RSC_AUX_SW] = swFlag_reg;
        readMux[`RSC_AUX_PIN] = pinFlag_reg;
        readMux[`RSC_AUX_HF] = hfFlag_reg;
        readMux[`RSC_AUX_GF2] = gf2_reg;
      end
      `RSC_IDX_BOD0: begin
        readMux[`RSC_BOD_EN] = borEnable_reg;
        readMux[`RSC_BOD_FLAG] = borFlag_reg;
        readMux[`RSC_BOD_STAT] = borLowS && borEnable_reg;
      end
      `RSC_IDX_IRQ_STAT: begin
        readMux[`RSC_EVT_W-1:0] = irqStat_reg;
      end
      `RSC_IDX_IRQ_MASK: begin
        readMux[`RSC_EVT_W-1:0] = irqMask_reg;
      end
      default: begin
        readMux = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RSC_RESP_OKAY;
    end else if (rdFire) begin
      rvalid <= 1'b1;
      rdata <= {24'h000000, readMux};
      rresp <= regMapped(rdIdx) ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Control fields cleared by any reset; brown-out enable loads borEnableConfig
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gf_reg <= 2'h0;
      powerDown_reg <= 1'b0;
      gf2_reg <= 1'b0;
      borEnable_reg <= 1'b0;
    end else if (coreReset) begin
      gf_reg <= 2'h0;
      powerDown_reg <= 1'b0;
      gf2_reg <= 1'b0;
      borEnable_reg <= borEnableConfig;
    end else begin
      if (state_next == rsc_pkg::RSC_WAKE) begin
        powerDown_reg <= 1'b0;
      end else if (wrLane && wrIdx == `RSC_IDX_PWR) begin
        powerDown_reg <= wrByte[`RSC_PWR_PD];
      end
      if (wrLane && wrIdx == `RSC_IDX_PWR) begin
        gf_reg <= wrByte[`RSC_PWR_GF_HI:`RSC_PWR_GF_LO];
      end
      if (wrLane && wrIdx == `RSC_IDX_AUX1) begin
        gf2_reg <= wrByte[`RSC_AUX_GF2];
      end
      if (wrLane && wrIdx == `RSC_IDX_BOD0) begin
        borEnable_reg <= wrByte[`RSC_BOD_EN];
      end
    end
  end

  // ****************************************
  // Cause flags, kept across internal resets
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      coldFlag_reg <= 1'b1;
    end else if (wrLane && wrIdx == `RSC_IDX_PWR) begin
      coldFlag_reg <= wrByte[`RSC_PWR_COLD];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      borFlag_reg <= 1'b0;
    end else if (borTrip && state_reg != rsc_pkg::RSC_RESET) begin
      borFlag_reg <= 1'b1;
    end else if (wrLane && wrIdx == `RSC_IDX_BOD0) begin
      borFlag_reg <= wrByte[`RSC_BOD_FLAG];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinFlag_reg <= 1'b0;
      hfFlag_reg <= 1'b0;
      swFlag_reg <= 1'b0;
    end else begin
      if (pinEvent) begin
        pinFlag_reg <= 1'b1;
      end else if (wrLane && wrIdx == `RSC_IDX_AUX1) begin
        pinFlag_reg <= wrByte[`RSC_AUX_PIN];
      end
      if (pcOverflow) begin
        hfFlag_reg <= 1'b1;
      end else if (wrLane && wrIdx == `RSC_IDX_AUX1) begin
        hfFlag_reg <= wrByte[`RSC_AUX_HF];
      end
      if (softwareRequest) begin
        swFlag_reg <= 1'b1;
      end else if (wrLane && wrIdx == `RSC_IDX_AUX1) begin
        swFlag_reg <= wrByte[`RSC_AUX_SW];
      end
    end
  end

  // ****************************************
  // Interrupt status and mask
  // ****************************************
  always_comb begin
    evt = '0;
    evt[`RSC_EVT_BOD] = borLowS && !borPrev_reg;
    evt[`RSC_EVT_HFDBG] = hfSuppressed;
    evt[`RSC_EVT_PIN] = pinEvent;
    evt[`RSC_EVT_WDT] = watchdogExpire;
    evt[`RSC_EVT_SW] = softwareRequest;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      borPrev_reg <= 1'b0;
      irqStat_reg <= '0;
      irqMask_reg <= '0;
    end else begin
      borPrev_reg <= borLowS;
      if (wrLane && wrIdx == `RSC_IDX_IRQ_STAT) begin
        irqStat_reg <= (irqStat_reg & ~wrByte[`RSC_EVT_W-1:0]) | evt;
      end else begin
        irqStat_reg <= irqStat_reg | evt;
      end
      if (wrLane && wrIdx == `RSC_IDX_IRQ_MASK) begin
        irqMask_reg <= wrByte[`RSC_EVT_W-1:0];
      end
    end
  end

  assign irq = |(irqStat_reg & irqMask_reg);

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence runTrip;
    state_reg == rsc_pkg::RSC_RUN && trip && !(powerDown_reg && pinLowS);
  endsequence

  trip_resets_core_a: assert property (runTrip |=> coreReset)
    else $error("Source did not reset the core");
  sfr_cleared_a: assert property (coreReset |=> gf_reg == 2'h0 && !powerDown_reg && !gf2_reg)
    else $error("Control fields survived reset");
  cold_kept_a: assert property (!$past(wrLane) |-> $stable(coldFlag_reg))
    else $error("Cold flag changed without a write");
  bor_flag_set_a: assert property (runTrip and borTrip |=> coreReset && borFlag_reg)
    else $error("Brown-out missed");
  pin_low_holds_a: assert property (coreReset && pinLowS |=> coreReset)
    else $error("Reset ended with pin low");
  hold_release_a: assert property (state_reg == rsc_pkg::RSC_HOLD && holdCount_reg == '0 && !trip
    |=> !coreReset)
    else $error("Reset not released");
  wake_before_reset_a: assert property (state_reg == rsc_pkg::RSC_WAKE |-> clockWakeRequest && !coreReset
    ##1 (clockWakeRequest || coreReset))
    else $error("Reset before clock wake");
  pin_flag_set_a: assert property (pinEvent |=> pinFlag_reg [*1] ##0 coreReset)
    else $error("Pin flag not set");
  hf_debug_only_a: assert property (state_reg == rsc_pkg::RSC_RUN && hfSuppressed && !pinValid && !borTrip
    && !watchdogExpire && !softwareRequest && !(powerDown_reg && pinLowS) |=> !coreReset && hfFlag_reg)
    else $error("Suppressed fault caused reset");
  hf_flag_set_a: assert property (pcOverflow |=> hfFlag_reg)
    else $error("Hard fault flag not set");

endmodule : rsc_controller
`default_nettype wire

// File: testbench/rsc_far_side.sv
// Purpose: Model of the reset pin driver and the monitored supply
// Assumes: Pin has a pull-up, so a released pin reads high
// Notes: Clock restart takes STABLE_DLY+1 cycles after the wake request
`timescale 1ns/1ps
`default_nettype none
module rsc_far_side #(
  parameter int STABLE_DLY = 8
) (
  // Clock
  input wire logic clk,
  // Wake handshake
  input wire logic clockWakeRequest,
  // Pin and supply
  output logic resetPin_b,
  output logic brownoutLow,
  output logic clockStable
);
  int cnt;

  initial begin
    resetPin_b = 1'b1;
    brownoutLow = 1'b0;
    clockStable = 1'b1;
    cnt = 0;
  end

  // ****************************************
  // Pin low for n cycles, then released
  // ****************************************
  task pin_low(input int n);
    @(posedge clk);
    resetPin_b <= 1'b0;
    repeat (n) @(posedge clk);
    resetPin_b <= 1'b1;
  endtask : pin_low

  task set_brown(input logic v);
    @(posedge clk);
    brownoutLow <= v;
  endtask : set_brown

  // Power-down stops the system clock
  task enter_pd;
    @(posedge clk);
    clockStable <= 1'b0;
  endtask : enter_pd

  // Clock restarts and settles after a wake request
  always @(posedge clk) begin
    if (clockWakeRequest && !clockStable) begin
      if (cnt == STABLE_DLY) clockStable <= 1'b1;
      else cnt <= cnt + 1;
    end else cnt <= 0;
  end
endmodule : rsc_far_side
`default_nettype wire

// File: testbench/rsc_tb.sv
// Purpose: Self-checking bench of the reset source controller
// Assumes: Register bus is AXI4-Lite, byte address is four times the index
// Notes: HOLD_CYC shortened to 2
`timescale 1ns/1ps
`default_nettype none
`include "rsc_regs.svh"
module testbench;
  localparam int PMIN = `RSC_PIN_MIN_LOW;
  logic clk, rst_b, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [15:0] bootAddress;
  logic coreReset, clockWakeRequest, irq, resetPin_b, brownoutLow, clockStable;
  logic pcOverflow, watchdogExpire, softwareRequest, debugMode, debugEnableConfig, borEnableConfig;
  int err_total, n_tests;

  rsc_controller #(.HOLD_CYC(2)) DUT (.clk(clk), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .resetPin_b(resetPin_b), .brownoutLow(brownoutLow),
    .clockStable(clockStable), .pcOverflow(pcOverflow), .watchdogExpire(watchdogExpire),
    .softwareRequest(softwareRequest), .debugMode(debugMode), .debugEnableConfig(debugEnableConfig),
    .borEnableConfig(borEnableConfig), .coreReset(coreReset), .clockWakeRequest(clockWakeRequest),
    .bootAddress(bootAddress), .irq(irq));

  rsc_far_side PARTNER (.clk(clk), .clockWakeRequest(clockWakeRequest), .resetPin_b(resetPin_b),
    .brownoutLow(brownoutLow), .clockStable(clockStable));

  // ****************************************
  // Checks and bus tasks
  // ****************************************
  task end_sim;
    $display("Mismatches %0d, compares %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er = `RSC_RESP_OKAY,
          input logic [3:0] s = 4'hF);
    int i;
    @(posedge clk);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    @(posedge clk);
    i = 1;
    while (awready !== 1'b1 && i < 100) begin @(posedge clk); i++; end
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    @(posedge clk);
    while (bvalid !== 1'b1 && i < 100) begin @(posedge clk); i++; end
    bready <= 1'b0;
    if (i >= 100) begin err_total++; end_sim(); end
    chk({30'h0, bresp}, {30'h0, er});
  endtask : wr

  task rdc(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
    int i;
    @(posedge clk);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge clk);
    i = 1;
    while (arready !== 1'b1 && i < 100) begin @(posedge clk); i++; end
    arvalid <= 1'b0;
    @(posedge clk);
    while (rvalid !== 1'b1 && i < 100) begin @(posedge clk); i++; end
    rready <= 1'b0;
    if (i >= 100) begin err_total++; end_sim(); end
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
  endtask : rdc

  // Waits for coreReset (k=0) or clockWakeRequest (k=1) to reach v
  task wt(input int k, input logic v);
    int i;
    i = 0;
    while (((k == 0) ? coreReset : clockWakeRequest) !== v) begin
      @(posedge clk);
      #1;
      i++;
      if (i > 400) begin err_total++; end_sim(); end
    end
  endtask : wt

  task pulse(input int k);
    @(posedge clk);
    {softwareRequest, watchdogExpire, pcOverflow} <= 3'h1 << k;
    @(posedge clk);
    {softwareRequest, watchdogExpire, pcOverflow} <= 3'h0;
  endtask : pulse

  task gap(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : gap

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
    {pcOverflow, watchdogExpire, softwareRequest, debugMode, debugEnableConfig} = '0;
    borEnableConfig = 1'b1;
    err_total = 0;
    n_tests = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    gap(1);
    chk(coreReset, 1'b1);
    chk(bootAddress, `RSC_BOOT_ADDR);
    rdc(`RSC_IDX_PWR, 32'h10, `RSC_RESP_OKAY);
    rdc(`RSC_IDX_AUX1, 32'h00, `RSC_RESP_OKAY);
    rdc(`RSC_IDX_BOD0, 32'h04, `RSC_RESP_OKAY);
    rdc(8'h10, 32'h00, `RSC_RESP_SLVERR);
    wr(8'h10, 32'hFF, `RSC_RESP_SLVERR);
    wt(0, 1'b0);
    wr(`RSC_IDX_PWR, 32'h0C);
    rdc(`RSC_IDX_PWR, 32'h0C, `RSC_RESP_OKAY);
    wr(`RSC_IDX_PWR, 32'h10, `RSC_RESP_OKAY, 4'hE);
    rdc(`RSC_IDX_PWR, 32'h0C, `RSC_RESP_OKAY);
    PARTNER.pin_low(PMIN - 4);
    PARTNER.pin_low(PMIN - 4);
    gap(8);
    rdc(`RSC_IDX_AUX1, 32'h00, `RSC_RESP_OKAY);
    wr(`RSC_IDX_IRQ_MASK, 32'h1F);
    fork
      PARTNER.pin_low(60);
      begin
        wt(0, 1'b1);
        gap(20);
        chk(coreReset, 1'b1);
      end
    join
    wt(0, 1'b0);
    chk(irq, 1'b1);
    rdc(`RSC_IDX_PWR, 32'h00, `RSC_RESP_OKAY);
    rdc(`RSC_IDX_AUX1, 32'h40, `RSC_RESP_OKAY);
    rdc(`RSC_IDX_IRQ_STAT, 32'h04, `RSC_RESP_OKAY);
    PARTNER.set_brown(1'b1);
    wt(0, 1'b1);
    gap(30);
    chk(coreReset, 1'b1);
    PARTNER.set_brown(1'b0);
    wt(0, 1'b0);
    rdc(`RSC_IDX_BOD0, 32'h06, `RSC_RESP_OKAY);
    rdc(`RSC_IDX_AUX1, 32'h40, `RSC_RESP_OKAY);
    wr(`RSC_IDX_BOD0, 32'h00);
    rdc(`RSC_IDX_BOD0, 32'h00, `RSC_RESP_OKAY);
    PARTNER.set_brown(1'b1);
    gap(30);
    chk(coreReset, 1'b0);
    PARTNER.set_brown(1'b0);
    rdc(`RSC_IDX_IRQ_STAT, 32'h05, `RSC_RESP_OKAY);
    wr(`RSC_IDX_AUX1, 32'h00);
    wr(`RSC_IDX_IRQ_STAT, 32'h1F);
    chk(irq, 1'b0);
    debugMode <= 1'b1;
    pulse(0);
    gap(10);
    chk(coreReset, 1'b0);
    rdc(`RSC_IDX_AUX1, 32'h20, `RSC_RESP_OKAY);
    rdc(`RSC_IDX_IRQ_STAT, 32'h02, `RSC_RESP_OKAY);
    debugEnableConfig <= 1'b1;
    wr(`RSC_IDX_AUX1, 32'h08);
    pulse(0);
    wt(0, 1'b1);
    wt(0, 1'b0);
    rdc(`RSC_IDX_AUX1, 32'h20, `RSC_RESP_OKAY);
    wr(`RSC_IDX_AUX1, 32'h00);
    wr(`RSC_IDX_IRQ_STAT, 32'h1F);
    wr(`RSC_IDX_IRQ_MASK, 32'h00);
    debugMode <= 1'b0;
    borEnableConfig <= 1'b0;
    pulse(1);
    wt(0, 1'b1);
    wt(0, 1'b0);
    rdc(`RSC_IDX_AUX1, 32'h00, `RSC_RESP_OKAY);
    rdc(`RSC_IDX_BOD0, 32'h00, `RSC_RESP_OKAY);
    chk(irq, 1'b0);
    rdc(`RSC_IDX_IRQ_STAT, 32'h08, `RSC_RESP_OKAY);
    wr(`RSC_IDX_IRQ_MASK, 32'h08);
    chk(irq, 1'b1);
    wr(`RSC_IDX_IRQ_STAT, 32'h08);
    chk(irq, 1'b0);
    pulse(2);
    wt(0, 1'b1);
    wt(0, 1'b0);
    rdc(`RSC_IDX_AUX1, 32'h80, `RSC_RESP_OKAY);
    wr(`RSC_IDX_AUX1, 32'h00);
    wr(`RSC_IDX_PWR, 32'h02);
    PARTNER.enter_pd();
    fork
      PARTNER.pin_low(80);
      begin
        wt(1, 1'b1);
        chk(coreReset, 1'b0);
        wt(0, 1'b1);
        chk(clockStable, 1'b1);
      end
    join
    wt(0, 1'b0);
    rdc(`RSC_IDX_AUX1, 32'h40, `RSC_RESP_OKAY);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
